// ==== bench/host_spi_model.sv ====
/*
 * host model for the flash pin block: select, serial clock, lanes 2 and 3.
 * assumes clk_sys from the bench; released lanes read high by pull-up.
 */
`timescale 1ns/1ps
module host_spi_model (
   input  wire logic  clk_sys,
   output logic       serialClk,
   output logic       chipSelect_b,
   output logic [1:0] laneDrv,
   output logic [1:0] laneEn
);
   initial begin
      serialClk    = 1'b0;
      chipSelect_b = 1'b1;
      laneDrv      = 2'b11;
      laneEn       = 2'b00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   // 200 ns link period; clock stands still outside frames
   task automatic edgePair();
      tick(4);
      serialClk = 1'b1;
      tick(4);
      serialClk = 1'b0;
   endtask
   task automatic frameStart();
      tick(1);
      chipSelect_b = 1'b0;
      tick(4);
   endtask
   task automatic drive(input logic [1:0] en, input logic [1:0] val);
      laneEn  = en;
      laneDrv = val;
   endtask
   // lane 3 forced high with select unless the memory drives it after a host-bound transfer
   task automatic frameEnd(input logic toMemory);
      tick(1);
      chipSelect_b = 1'b1;
      laneEn       = {toMemory, 1'b0};
      laneDrv      = 2'b11;
      tick(4);
      laneEn = 2'b00;
   endtask
   task automatic sharedLow(input logic csHigh, input int n);
      tick(1);
      chipSelect_b = csHigh;
      drive(2'b10, 2'b00);
      tick(n);
      drive(2'b10, 2'b11);
      tick(2);
      chipSelect_b = 1'b1;
      laneEn       = 2'b00;
   endtask
endmodule

// ==== bench/test_flash_protect_reset_pins.sv ====
/*
 * self-checking bench for the flash pin block.
 * assumes the host model drives the pins; recovery shortened to 10 cycles.
 */
`timescale 1ns/1ps
module test_flash_protect_reset_pins;
   import flash_pins_pkg::*;
   localparam int unsigned REC = 10;
   logic         clk_sys = 1'b0;
   logic         rst_b = 1'b0;
   logic         reset_b = 1'b1;
   logic         statusWriteDisableNv = 1'b0;
   logic         quadEnable = 1'b0;
   logic         resetEnable = 1'b0;
   logic         doubleRate = 1'b0;
   logic         driveEnable = 1'b0;
   logic         hostBound = 1'b0;
   logic [3:0]   txNibble = 4'h0;
   logic         txNibbleValid = 1'b0;
   regWriteReq_t regWrite = '0;
   logic         serialClk, chipSelect_b, regWriteAccept, regWriteIgnored;
   logic         writeProtectActive, rxNibbleValid, hwResetActive, standbyReady;
   logic [3:0]   rxNibble;
   logic [1:0]   laneDrv, laneEn;
   quadDrive_t   quadDrive;
   int           failures = 0;
   int           checks = 0;
   // design drive wins; a released line reads high by pull-up
   wire logic wpPin = !quadDrive.outEnable_b[2] ? quadDrive.dataOut[2] : !laneEn[0] | laneDrv[0];
   wire logic l3Pin = !quadDrive.outEnable_b[3] ? quadDrive.dataOut[3] : !laneEn[1] | laneDrv[1];

   always #12.5 clk_sys = ~clk_sys;

   // one memory only on the lane 3 line
   host_spi_model host (.clk_sys(clk_sys), .serialClk(serialClk),
      .chipSelect_b(chipSelect_b), .laneDrv(laneDrv), .laneEn(laneEn));

   flash_protect_reset_pins #(.RECOVERY_CYC(REC)) uut (
      .clk_sys(clk_sys), .rst_b(rst_b), .serialClk(serialClk),
      .chipSelect_b(chipSelect_b), .writeProtect_b_in(wpPin), .quadLane3_in(l3Pin),
      .reset_b(reset_b), .statusWriteDisableNv(statusWriteDisableNv),
      .quadEnable(quadEnable), .resetEnable(resetEnable), .doubleRate(doubleRate),
      .driveEnable(driveEnable), .hostBound(hostBound), .txNibble(txNibble),
      .txNibbleValid(txNibbleValid), .regWrite(regWrite),
      .regWriteAccept(regWriteAccept), .regWriteIgnored(regWriteIgnored),
      .writeProtectActive(writeProtectActive), .rxNibble(rxNibble),
      .rxNibbleValid(rxNibbleValid), .quadDrive(quadDrive),
      .hwResetActive(hwResetActive), .standbyReady(standbyReady));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   // sample before the host's own changes land
   task automatic look();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic req(input logic write_registers_cmd, input logic [2:0] tgt, input logic drop);
      regWrite = '{writeRegisters: write_registers_cmd, writeAnyRegister: !write_registers_cmd, target: tgt};
      tick(1);
      regWrite = '0;
      check({regWriteIgnored, regWriteAccept}, {drop, !drop});
      tick(1);
   endtask
   task automatic testProtect();
      host.frameStart();
      statusWriteDisableNv = 1'b1;
      for (int lvl = 0; lvl < 2; lvl++) begin
         host.drive(2'b01, {1'b1, lvl[0]});
         tick(4);
         check(writeProtectActive, !lvl[0]);
         req(1'b1, TGT_OTHER, !lvl[0]);
         for (int t = 0; t < 5; t++) req(1'b0, t[2:0], !lvl[0] && t < 4);
      end
      host.drive(2'b01, 2'b10);
      quadEnable = 1'b1;
      tick(4);
      check(writeProtectActive, 1'b0);
      req(1'b1, TGT_STATUS1_NV, 1'b0);
      quadEnable = 1'b0;
      host.frameEnd(1'b1);
      $display("protect test done");
   endtask
   task automatic testReceive();
      logic got;
      quadEnable = 1'b1;
      host.frameStart();
      for (int i = 0; i < 4; i++) begin
         got = 1'b0;
         host.drive(2'b11, i[1:0]);
         fork
            host.edgePair();
            repeat (12) begin
               look();
               if (rxNibbleValid === 1'b1) begin
                  got = 1'b1;
                  check(rxNibble, {i[1:0], 2'b00});
               end
            end
         join
         check(got, 1'b1);
      end
      host.frameEnd(1'b1);
      quadEnable = 1'b0;
      $display("receive test done");
   endtask
   task automatic testDrive();
      logic early, hold, onRise;
      early = 1'b0;
      hold = 1'b0;
      onRise = 1'b0;
      quadEnable = 1'b1;
      hostBound = 1'b1;
      driveEnable = 1'b1;
      txNibble = 4'h5;
      txNibbleValid = 1'b1;
      host.frameStart();
      fork
         host.edgePair();
         repeat (16) begin
            look();
            if (serialClk === 1'b1 && quadDrive.outEnable_b !== 4'hF) early = 1'b1;
         end
      join
      check(early, 1'b0);
      check(quadDrive, {4'h5, 4'h0});
      // double rate: new nibble must already stand while the clock is high
      txNibble = 4'hA;
      doubleRate = 1'b1;
      fork
         host.edgePair();
         repeat (16) begin
            look();
            if (serialClk === 1'b1 && quadDrive.dataOut === 4'hA) onRise = 1'b1;
         end
      join
      check(onRise, 1'b1);
      doubleRate = 1'b0;
      driveEnable = 1'b0;
      txNibbleValid = 1'b0;
      fork
         host.frameEnd(1'b0);
         repeat (12) begin
            look();
            if (chipSelect_b && quadDrive.outEnable_b[3] === 1'b0 && quadDrive.dataOut[3] === 1'b1)
               hold = 1'b1;
         end
      join
      check(hold, 1'b1);
      check(quadDrive.outEnable_b, 4'hF);
      hostBound = 1'b0;
      quadEnable = 1'b0;
      $display("drive test done");
   endtask
   task automatic resetCase(input logic ded, input logic en, input logic quad,
                            input logic csHigh, input int n, input logic exp);
      logic saw;
      int   lowCnt;
      saw = 1'b0;
      lowCnt = 0;
      resetEnable = en;
      quadEnable = quad;
      fork
         if (ded) begin
            reset_b = 1'b0;
            tick(n);
            reset_b = 1'b1;
         end else host.sharedLow(csHigh, n);
         repeat (n + 30) begin
            look();
            saw = saw | (hwResetActive === 1'b1);
            lowCnt += (standbyReady !== 1'b1);
         end
      join
      check(saw, exp);
      check(lowCnt[7:0], 8'(exp ? REC : 0));
   endtask
   task automatic testReset();
      resetCase(1'b0, 1'b1, 1'b0, 1'b1, 6, 1'b0);
      resetCase(1'b0, 1'b1, 1'b0, 1'b1, 14, 1'b1);
      resetCase(1'b0, 1'b0, 1'b0, 1'b1, 14, 1'b0);
      resetCase(1'b0, 1'b1, 1'b1, 1'b0, 14, 1'b0);
      resetCase(1'b0, 1'b1, 1'b1, 1'b1, 14, 1'b1);
      resetCase(1'b1, 1'b0, 1'b0, 1'b1, 6, 1'b0);
      resetCase(1'b1, 1'b0, 1'b0, 1'b1, 14, 1'b1);
      host.frameStart();
      resetCase(1'b1, 1'b0, 1'b0, 1'b0, 14, 1'b1);
      host.frameEnd(1'b1);
      quadEnable = 1'b0;
      $display("reset test done");
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      tick(20);
      rst_b = 1'b1;
      tick(2);
      testProtect();
      testReceive();
      testDrive();
      testReset();
      finish_test();
   end
   // whole run needs well under 3000 cycles
   initial begin
      repeat (6000) @(posedge clk_sys);
      failures++;
      finish_test();
   end
endmodule

// ==== rtl/flash_pins_pkg.sv ====
/*
 * Package for the flash pin-function block: timing constants, bit positions,
 * register-write target codes and the packed carriers shared by the modules.
 * Assumes the core clock clk_sys runs at 40 MHz.
 */
package flash_pins_pkg;

   localparam int unsigned CLK_SYS_MHZ         = 40;
   // least reset pulse, in ns; rounds up
   localparam int unsigned RESET_PULSE_MIN_NS  = 200;
   localparam int unsigned RESET_PULSE_CYCLES  =
      (RESET_PULSE_MIN_NS * CLK_SYS_MHZ + 999) / 1000;
   // longest reset recovery, in ns; rounds down
   localparam int unsigned RESET_RECOVERY_NS   = 10000;
   localparam int unsigned RESET_RECOVERY_CYCLES =
      (RESET_RECOVERY_NS * CLK_SYS_MHZ) / 1000;
   // lane 3 held high after a host-bound transfer, in ns; rounds up
   localparam int unsigned DESELECT_NS         = 50;
   localparam int unsigned DESELECT_CYCLES     =
      (DESELECT_NS * CLK_SYS_MHZ + 999) / 1000;

   localparam int unsigned CNT_W               = 16;

   localparam int unsigned WRITE_DISABLE_BIT   = 7;
   localparam int unsigned QUAD_BIT            = 1;
   localparam int unsigned RESET_EN_BIT        = 5;

   // write-any-register targets; all but TGT_OTHER are in the protected group
   localparam logic [2:0]  TGT_STATUS1_NV      = 3'h0;
   localparam logic [2:0]  TGT_STATUS1_V       = 3'h1;
   localparam logic [2:0]  TGT_CONFIG1_NV      = 3'h2;
   localparam logic [2:0]  TGT_CONFIG1_V       = 3'h3;
   localparam logic [2:0]  TGT_OTHER           = 3'h4;

   typedef struct packed {
      logic       writeRegisters;
      logic       writeAnyRegister;
      logic [2:0] target;
   } regWriteReq_t;

   typedef struct packed {
      logic [3:0] dataOut;
      logic [3:0] outEnable_b;
   } quadDrive_t;

endpackage

// ==== rtl/flash_protect_reset_pins.sv ====
/*
 * Pin-function logic of a serial flash: write protection of the status-1 and
 * config-1 group, quad lanes 2 and 3, and the two hardware reset inputs.
 * Assumes the command decoder supplies register-write requests and the
 * quad output data; serial clock, chip select and pins are asynchronous.
 */
`timescale 1ns/1ps
module flash_protect_reset_pins
   import flash_pins_pkg::*;
#(
   parameter bit          HAS_RESET_PIN = 1'b1,
   parameter int unsigned RECOVERY_CYC  = RESET_RECOVERY_CYCLES
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic         serialClk,
   input  wire logic         chipSelect_b,
   input  wire logic         writeProtect_b_in,
   input  wire logic         quadLane3_in,
   input  wire logic         reset_b,
   input  wire logic         statusWriteDisableNv,
   input  wire logic         quadEnable,
   input  wire logic         resetEnable,
   input  wire logic         doubleRate,
   input  wire logic         driveEnable,
   input  wire logic         hostBound,
   input  wire logic [3:0]   txNibble,
   input  wire logic         txNibbleValid,
   input  wire regWriteReq_t regWrite,
   output logic              regWriteAccept,
   output logic              regWriteIgnored,
   output logic              writeProtectActive,
   output logic [3:0]        rxNibble,
   output logic              rxNibbleValid,
   output quadDrive_t        quadDrive,
   output logic              hwResetActive,
   output logic              standbyReady
);

   logic       sckMeta;
   logic       sckSync;
   logic       sckLast;
   logic       csMeta;
   logic       csSync;
   logic       csLast;
   logic       wpMeta;
   logic       wpSync;
   logic       sckRise;
   logic       sckFall;
   logic       protectHit;
   logic       isProtectedWrite;
   logic       sharedQualify;
   logic       sharedHeld;
   logic       dedicatedHeld;
   logic       sharedLevel;
   logic       resetRequest;
   logic [CNT_W-1:0] recoveryCount;
   logic [CNT_W-1:0] deselectCount;
   logic       lastWasHostBound;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sckMeta  <= 1'b0;
         sckSync  <= 1'b0;
         sckLast  <= 1'b0;
         csMeta   <= 1'b1;
         csSync   <= 1'b1;
         csLast   <= 1'b1;
         wpMeta   <= 1'b1;
         wpSync   <= 1'b1;
      end else begin
         sckMeta  <= serialClk;
         sckSync  <= sckMeta;
         sckLast  <= sckSync;
         csMeta   <= chipSelect_b;
         csSync   <= csMeta;
         csLast   <= csSync;
         wpMeta   <= writeProtect_b_in;
         wpSync   <= wpMeta;
      end
   end

   assign sckRise = sckSync && !sckLast;
   assign sckFall = !sckSync && sckLast;

   // protect function exists only outside quad mode
   assign protectHit = statusWriteDisableNv && !wpSync && !quadEnable;
   assign isProtectedWrite = regWrite.writeRegisters ||
      (regWrite.writeAnyRegister && (regWrite.target != TGT_OTHER));

   // blocked writes are dropped; regWriteIgnored flags each one instead of regWriteAccept
   always_ff @(posedge clk_sys) begin
      if (!rst_b || resetRequest) begin
         regWriteAccept     <= 1'b0;
         regWriteIgnored    <= 1'b0;
         writeProtectActive <= 1'b0;
      end else begin
         writeProtectActive <= protectHit;
         regWriteIgnored    <= isProtectedWrite && protectHit && !csSync;
         regWriteAccept     <= (regWrite.writeRegisters || regWrite.writeAnyRegister)
                               && !csSync && !(isProtectedWrite && protectHit);
      end
   end

   // lanes 2 and 3 captured only on rising serial clock while selected
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rxNibble      <= 4'h0;
         rxNibbleValid <= 1'b0;
      end else begin
         rxNibbleValid <= 1'b0;
         if (sckRise && quadEnable && !csSync) begin
            // one synchroniser per pin, so lane and reset views never disagree
            rxNibble      <= {sharedLevel, wpSync, 2'h0};
            rxNibbleValid <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         lastWasHostBound <= 1'b0;
      end else if (!csSync) begin
         lastWasHostBound <= hostBound && quadEnable;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         deselectCount <= '0;
      end else if (csSync && !csLast && lastWasHostBound) begin
         deselectCount <= CNT_W'(DESELECT_CYCLES);
      end else if (!csSync) begin
         deselectCount <= '0;
      end else if (deselectCount != '0) begin
         deselectCount <= deselectCount - 1'b1;
      end
   end

   // output changes after falling edge (single rate) or any edge (double)
   always_ff @(posedge clk_sys) begin
      if (!rst_b || resetRequest) begin
         quadDrive <= '{dataOut: 4'h0, outEnable_b: 4'hF};
      end else if (csSync) begin
         // drive lane 3 high briefly so the pin never looks like reset
         quadDrive.dataOut[3]     <= 1'b1;
         quadDrive.outEnable_b    <= (deselectCount != '0) ? 4'h7 : 4'hF;
      end else if (driveEnable && quadEnable && txNibbleValid &&
                   (sckFall || (doubleRate && sckRise))) begin
         quadDrive.dataOut     <= txNibble;
         quadDrive.outEnable_b <= 4'h0;
      end else if (!driveEnable) begin
         quadDrive.outEnable_b <= 4'hF;
      end
   end

   // shared pin is reset only when enabled and deselected, in either quad setting
   assign sharedQualify = resetEnable && csSync;

   level_filter #(
      .HOLD_CYCLES(RESET_PULSE_CYCLES)
   ) u_sharedFilter (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .pinIn    (quadLane3_in),
      .qualify  (sharedQualify),
      .syncLevel(sharedLevel),
      .held     (sharedHeld)
   );

   // a package without the pin sees it tied high
   level_filter #(
      .HOLD_CYCLES(RESET_PULSE_CYCLES + 1)
   ) u_dedicatedFilter (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .pinIn    (HAS_RESET_PIN ? reset_b : 1'b1),
      .qualify  (1'b1),
      .syncLevel(),
      .held     (dedicatedHeld)
   );

   assign resetRequest = sharedHeld || dedicatedHeld;

   // restarts on every request, even mid-command or mid-reset
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         recoveryCount <= '0;
         hwResetActive <= 1'b0;
         standbyReady  <= 1'b0;
      end else if (resetRequest) begin
         recoveryCount <= CNT_W'(RECOVERY_CYC);
         hwResetActive <= 1'b1;
         standbyReady  <= 1'b0;
      end else if (recoveryCount > CNT_W'(1)) begin
         recoveryCount <= recoveryCount - 1'b1;
      end else begin
         recoveryCount <= '0;
         hwResetActive <= 1'b0;
         standbyReady  <= 1'b1;
      end
   end

   a_reset_start: assert property (@(posedge clk_sys) disable iff (!rst_b)
      resetRequest |=> hwResetActive && !standbyReady)
      else $error("reset request did not start reset");

   a_shared_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !resetEnable throughout (!resetEnable [*2]) |-> !sharedHeld)
      else $error("shared pin reset while disabled");

   a_shared_quad: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !$past(csSync) |-> !sharedHeld)
      else $error("shared pin reset while selected");

   a_protect_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (regWrite.writeRegisters && protectHit && !csSync && !resetRequest)
      |=> regWriteIgnored && !regWriteAccept)
      else $error("protected write accepted");

   a_quad_noprot: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $past(quadEnable) |-> !writeProtectActive)
      else $error("protect active in quad mode");

   a_desel_float: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (csSync && deselectCount == '0 && $past(csSync) && !resetRequest)
      |=> quadDrive.outEnable_b == 4'hF)
      else $error("outputs driven while deselected");

   a_lane3_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (csSync && deselectCount != '0 && !resetRequest)
      |=> !quadDrive.outEnable_b[3] && quadDrive.dataOut[3])
      else $error("lane 3 not held high after read");

   a_recover_end: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (recoveryCount == CNT_W'(1) && !resetRequest) |=> standbyReady)
      else $error("recovery did not reach standby");

   a_rx_rise: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rxNibbleValid |-> $past(sckRise) && $past(quadEnable))
      else $error("lane sample not on rising edge");

endmodule

// ==== rtl/level_filter.sv ====
/*
 * Low-level filter: two-flop synchroniser, then a counter that pulses
 * once when the synchronised input has stayed low and qualified for
 * HOLD_CYCLES clk_sys cycles. Assumes an asynchronous input level.
 */
`timescale 1ns/1ps
module level_filter
   import flash_pins_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = 1
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic pinIn,
   input  wire logic qualify,
   output logic      syncLevel,
   output logic      held
);

   logic             syncMeta;
   logic [CNT_W-1:0] lowCount;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         syncMeta  <= 1'b1;
         syncLevel <= 1'b1;
      end else begin
         syncMeta  <= pinIn;
         syncLevel <= syncMeta;
      end
   end

   // pulse once per low period, so a long hold does not restart reset
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         lowCount <= '0;
         held     <= 1'b0;
      end else if (syncLevel || !qualify) begin
         lowCount <= '0;
         held     <= 1'b0;
      end else if (lowCount < CNT_W'(HOLD_CYCLES)) begin
         lowCount <= lowCount + 1'b1;
         held     <= (lowCount == CNT_W'(HOLD_CYCLES - 1));
      end else begin
         held     <= 1'b0;
      end
   end

endmodule
